// [verilog/bmcl_loader.sv]
/*
 * Boot mode configuration loader: drives the serial mode clock, shifts in
 * the stream after power good, and holds the decoded mode fields.
 * Assumes power_good, cold and warm reset and serial data are asynchronous pins.
 */
// Function
// - Bits 21-24 give cache write deassert delay, 3 to 15.
// - Bits 25-26 give second cache write assert delay, 1 to 3.
// - Bits 27-28 give first cache write assert delay, 1 to 3.
// - Bit 29 gives cache write recovery, zero or one cycle.
// - Bits 30-32 give cache disable time, 2 to 7.
// - Bits 33-36 give second cache read cycle time, 3 to 15.
// - Bits 37-40 give first cache read cycle time, 4 to 15.
// - Bits 47-49 select reduced power clock divisor 2, 4, 8, 16.
// - Bits 50-52 select output drive point half, three quarter, full.
// - Bits 53-56, 53 first, load initial pull-down rate.
// - Bits 57-60, 57 first, load initial pull-up rate.
// - Bit 61 runs slew loop only during cold reset.
// - Bit 62 runs slew loop during cold reset and normal operation.
// - Bit 63 set disables the clock generation loops.
// - Bit 64 chooses floating outputs in cold only or either reset.
// - Mode clock is clock over 256; data sampled in step.
// - After power good, read exactly 256 stream bits.
// - After load, keep clock toggling and ignore further data.
`timescale 1ns/1ps
`default_nettype none
module bmcl_loader
    import bmcl_pkg::*;
#(
    parameter int BITS = STREAM_BITS
) (
    input wire logic clk, // Primary clock, 10 MHz.
    input wire logic reset, // Asynchronous reset, active high.
    input wire logic power_good, // Power good pin.
    input wire logic cold_reset_in, // Cold reset pin.
    input wire logic warm_reset_in, // Warm reset pin.
    input wire logic reduced_power_control, // Reduced power mode request.
    input wire logic config_serial_in, // Serial mode data pin.
    output logic config_serial_clock, // Serial mode clock pin.
    output logic load_done, // Stream fully loaded.
    output logic [3:0] cache_write_deassert_delay, // Write deassert delay.
    output logic [1:0] cache_write_assert_delay_second, // Second assert delay.
    output logic [1:0] cache_write_assert_delay_first, // First assert delay.
    output logic cache_write_recovery, // Write recovery cycles.
    output logic [2:0] cache_disable_time, // Disable time.
    output logic [3:0] cache_read_cycle_time_second, // Second read cycle time.
    output logic [3:0] cache_read_cycle_time_first, // First read cycle time.
    output logic package_size_select, // Package size bit.
    output logic [2:0] low_power_clock_divisor, // Divisor code.
    output logic [4:0] pipe_divide_ratio, // Active pipeline divide ratio.
    output logic drive_point_half, // Drive at half period.
    output logic drive_point_three_quarter, // Drive at three quarters.
    output logic drive_point_full, // Drive at full period.
    output logic [3:0] initial_pulldown_rate, // Initial pull-down state.
    output logic [3:0] initial_pullup_rate, // Initial pull-up state.
    output logic slew_loop_enable_in_cold_reset, // Bit 61 as held.
    output logic slew_loop_enable_always, // Bit 62 as held.
    output logic slew_loop_run, // Slew feedback loop running now.
    output logic clock_loop_disable, // Clock loops disabled.
    output logic reset_float_select, // Bit 64 as held.
    output logic output_float, // Output-only pins float now.
    output logic reserved_error // Reserved position or value seen.
);
    localparam int CW = $clog2(BITS + 1);
    localparam int DW = $clog2(MODE_CLOCK_DIV);

    // Returns a field of the stream, with its highest position as its MSB.
    function automatic logic [3:0] field(input logic [BITS-1:0] s, input int lsb,
                                         input int width);
        logic [3:0] f;
        f = 4'h0;
        for (int i = 0; i < 4; i++) begin
            if (i < width) begin
                f[i] = s[lsb + i];
            end
        end
        return f;
    endfunction : field

    // Three-stage synchronisers: first stage feeds only the second.
    logic [SYNC_STAGES-1:0] pg_sync;
    logic [SYNC_STAGES-1:0] cold_sync;
    logic [SYNC_STAGES-1:0] warm_sync;
    logic [SYNC_STAGES-1:0] din_sync;
    logic pg_level;
    logic cold_level;
    logic warm_level;
    logic din_level;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pg_sync <= '0;
            cold_sync <= '0;
            warm_sync <= '0;
            din_sync <= '0;
        end else begin
            pg_sync <= {pg_sync[1:0], power_good};
            cold_sync <= {cold_sync[1:0], cold_reset_in};
            warm_sync <= {warm_sync[1:0], warm_reset_in};
            din_sync <= {din_sync[1:0], config_serial_in};
        end
    end

    // A level counts only once stages two and three agree.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pg_level <= 1'b0;
            cold_level <= 1'b0;
            warm_level <= 1'b0;
            din_level <= 1'b0;
        end else begin
            if (pg_sync[1] == pg_sync[2]) pg_level <= pg_sync[2];
            if (cold_sync[1] == cold_sync[2]) cold_level <= cold_sync[2];
            if (warm_sync[1] == warm_sync[2]) warm_level <= warm_sync[2];
            if (din_sync[1] == din_sync[2]) din_level <= din_sync[2];
        end
    end

    // Free running divider; the mode clock never stops, even after the load.
    logic [DW-1:0] div_count;
    logic [DW-1:0] next_div_count;
    wire rise_point = (div_count == DW'(HALF_DIV - 1));
    wire sample_point = (div_count == DW'(MODE_CLOCK_DIV - 1));
    assign next_div_count = div_count + DW'(1);
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div_count <= '0;
            config_serial_clock <= 1'b0;
        end else begin
            div_count <= next_div_count;
            if (rise_point) config_serial_clock <= 1'b1;
            else if (sample_point) config_serial_clock <= 1'b0;
        end
    end

    // Load sequencer; a rising power good restarts the load.
    bmcl_state_type state;
    bmcl_state_type next_state;
    logic pg_prev;
    logic [CW-1:0] bit_count;
    wire pg_rise = pg_level && !pg_prev;
    // Data are sampled at the falling edge of the mode clock, a half period
    // after the rising edge, which covers the data setup the source needs.
    wire take_bit = (state == BMCL_LOAD) && sample_point;
    wire last_bit = take_bit && (bit_count == CW'(BITS - 1));
    always_comb begin
        next_state = state;
        unique case (state)
            BMCL_IDLE: if (pg_rise) next_state = BMCL_LOAD;
            BMCL_LOAD: if (last_bit) next_state = BMCL_DONE;
            BMCL_DONE: if (pg_rise) next_state = BMCL_LOAD;
        endcase
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= BMCL_IDLE;
            pg_prev <= 1'b0;
            bit_count <= '0;
        end else begin
            state <= next_state;
            pg_prev <= pg_level;
            if (pg_rise) bit_count <= '0;
            else if (take_bit) bit_count <= bit_count + CW'(1);
        end
    end

    logic [BITS-1:0] stream;
    bmcl_shift_mem #(.DEPTH(BITS)) u_store (
        .clk(clk),
        .reset(reset),
        .clear(pg_rise),
        .shift(take_bit),
        .bit_in(din_level),
        .data(stream)
    );

    // Decoded views of the completed stream.
    wire [3:0] f_pulldown = field(stream, PULLDOWN_MSB_POS, 4);
    wire [3:0] f_pullup = field(stream, PULLUP_MSB_POS, 4);
    wire [2:0] f_drive = 3'(field(stream, DRIVE_LSB, 3));
    wire [2:0] f_div = 3'(field(stream, DIVISOR_LSB, 3));
    wire resv_pos = (|stream[RESV_LO_MSB:RESV_LO_LSB]) || (|stream[BITS-1:RESV_HI_LSB]);
    wire resv_val = f_div[2] || (field(stream, DISABLE_LSB, 3) == 4'h0);
    wire finish = last_bit;

    // Fields latch on the cycle after the last bit and then hold.
    logic capture;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            capture <= 1'b0;
            load_done <= 1'b0;
        end else begin
            capture <= finish;
            if (pg_rise) load_done <= 1'b0;
            else if (capture) load_done <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cache_write_deassert_delay <= 4'h0;
            cache_write_assert_delay_second <= 2'h0;
            cache_write_assert_delay_first <= 2'h0;
            cache_write_recovery <= 1'b0;
            cache_disable_time <= 3'h0;
            cache_read_cycle_time_second <= 4'h0;
            cache_read_cycle_time_first <= 4'h0;
            package_size_select <= 1'b0;
            low_power_clock_divisor <= 3'h0;
            initial_pulldown_rate <= PULLDOWN_RESET;
            initial_pullup_rate <= PULLUP_RESET;
            slew_loop_enable_in_cold_reset <= 1'b0;
            slew_loop_enable_always <= 1'b0;
            clock_loop_disable <= 1'b0;
            reset_float_select <= 1'b0;
            reserved_error <= 1'b0;
        end else if (capture) begin
            cache_write_deassert_delay <= field(stream, WR_DEASSERT_LSB, 4);
            cache_write_assert_delay_second <= 2'(field(stream, WR_ASSERT2_LSB, 2));
            cache_write_assert_delay_first <= 2'(field(stream, WR_ASSERT1_LSB, 2));
            cache_write_recovery <= stream[WR_RECOVERY_POS];
            cache_disable_time <= 3'(field(stream, DISABLE_LSB, 3));
            cache_read_cycle_time_second <= field(stream, READ2_LSB, 4);
            cache_read_cycle_time_first <= field(stream, READ1_LSB, 4);
            package_size_select <= stream[PKG_SIZE_POS];
            low_power_clock_divisor <= f_div;
            // Bit 53 and bit 57 are the MSBs here, so the fields are reversed.
            initial_pulldown_rate <= {f_pulldown[0], f_pulldown[1], f_pulldown[2],
                                      f_pulldown[3]};
            initial_pullup_rate <= {f_pullup[0], f_pullup[1], f_pullup[2], f_pullup[3]};
            slew_loop_enable_in_cold_reset <= stream[SLEW_COLD_POS];
            slew_loop_enable_always <= stream[SLEW_ALWAYS_POS];
            clock_loop_disable <= stream[CLOCK_LOOP_POS];
            reset_float_select <= stream[FLOAT_SEL_POS];
            reserved_error <= resv_pos || resv_val;
        end
    end

    // Drive point decode; one of three is always selected after the load.
    logic [2:0] drive_code;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            drive_code <= 3'h0;
        end else if (capture) begin
            drive_code <= f_drive;
        end
    end
    wire next_half = (drive_code <= DRIVE_HALF_MAX);
    wire next_tq = (drive_code > DRIVE_HALF_MAX) && (drive_code <= DRIVE_TQ_MAX);
    wire next_full = (drive_code > DRIVE_TQ_MAX);

    // Run-time controls follow the reset pins and the held mode bits.
    wire next_slew = (slew_loop_enable_in_cold_reset && cold_level)
                     || slew_loop_enable_always;
    wire next_float = cold_level || (reset_float_select && warm_level);
    // Divide ratio is one unless reduced power is on; reserved codes give 16.
    wire [4:0] next_ratio = !reduced_power_control ? 5'h01 :
                            (low_power_clock_divisor[2] ? 5'h10 :
                             5'(5'h02 << low_power_clock_divisor[1:0]));
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            drive_point_half <= 1'b1;
            drive_point_three_quarter <= 1'b0;
            drive_point_full <= 1'b0;
            slew_loop_run <= 1'b0;
            output_float <= 1'b1;
            pipe_divide_ratio <= 5'h01;
        end else begin
            drive_point_half <= next_half;
            drive_point_three_quarter <= next_tq;
            drive_point_full <= next_full;
            slew_loop_run <= next_slew;
            output_float <= next_float;
            pipe_divide_ratio <= next_ratio;
        end
    end

    // Checks on the loader behaviour.
    int unsigned taken_bits;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) taken_bits <= 0;
        else if (pg_rise) taken_bits <= 0;
        else if (take_bit) taken_bits <= taken_bits + 1;
    end
    mode_clock_period_a: assert property (@(posedge clk) disable iff (reset)
        $rose(config_serial_clock) |-> ##128 $fell(config_serial_clock) ##128 $rose(config_serial_clock))
        else $error("mode clock period wrong");
    bit_count_exact_a: assert property (@(posedge clk) disable iff (reset)
        $rose(load_done) |-> taken_bits == BITS)
        else $error("load did not take 256 bits");
    no_shift_done_a: assert property (@(posedge clk) disable iff (reset)
        load_done && !pg_rise |-> !take_bit)
        else $error("bit taken after load");
    fields_hold_a: assert property (@(posedge clk) disable iff (reset)
        load_done && !capture |=> $stable(cache_read_cycle_time_first) && $stable(initial_pullup_rate))
        else $error("mode field changed while held");
    float_cold_a: assert property (@(posedge clk) disable iff (reset)
        cold_level |=> output_float)
        else $error("outputs not floated in cold reset");
    float_warm_a: assert property (@(posedge clk) disable iff (reset)
        !cold_level && warm_level |=> output_float == reset_float_select)
        else $error("warm reset float wrong");
    slew_run_a: assert property (@(posedge clk) disable iff (reset)
        slew_loop_enable_always |=> slew_loop_run)
        else $error("slew loop not running");
    slew_cold_a: assert property (@(posedge clk) disable iff (reset)
        !slew_loop_enable_always && !cold_level |=> !slew_loop_run)
        else $error("slew loop running outside cold reset");
    drive_onehot_a: assert property (@(posedge clk) disable iff (reset)
        $onehot({drive_point_half, drive_point_three_quarter, drive_point_full}))
        else $error("drive point not one-hot");
    load_done_c: cover property (@(posedge clk) disable iff (reset) $rose(load_done));
    reload_c: cover property (@(posedge clk) disable iff (reset) load_done && pg_rise);
    reduced_c: cover property (@(posedge clk) disable iff (reset) pipe_divide_ratio == 5'h10);
endmodule : bmcl_loader
`default_nettype wire

// [verilog/bmcl_pkg.sv]
/*
 * Shared constants for the boot mode configuration loader.
 * Assumes a single 10 MHz primary clock domain.
 */
package bmcl_pkg;
    localparam int STREAM_BITS = 256;
    localparam int MODE_CLOCK_DIV = 256;
    localparam int HALF_DIV = MODE_CLOCK_DIV / 2;
    localparam int SYNC_STAGES = 3;
    // Field positions in the serial stream.
    localparam int WR_DEASSERT_LSB = 21;
    localparam int WR_ASSERT2_LSB = 25;
    localparam int WR_ASSERT1_LSB = 27;
    localparam int WR_RECOVERY_POS = 29;
    localparam int DISABLE_LSB = 30;
    localparam int READ2_LSB = 33;
    localparam int READ1_LSB = 37;
    localparam int RESV_LO_LSB = 41;
    localparam int RESV_LO_MSB = 45;
    localparam int PKG_SIZE_POS = 46;
    localparam int DIVISOR_LSB = 47;
    localparam int DRIVE_LSB = 50;
    localparam int PULLDOWN_MSB_POS = 53;
    localparam int PULLUP_MSB_POS = 57;
    localparam int SLEW_COLD_POS = 61;
    localparam int SLEW_ALWAYS_POS = 62;
    localparam int CLOCK_LOOP_POS = 63;
    localparam int FLOAT_SEL_POS = 64;
    localparam int RESV_HI_LSB = 65;
    // Reset values of the held mode fields and drive point decode limits.
    localparam logic [3:0] PULLDOWN_RESET = 4'hf;
    localparam logic [3:0] PULLUP_RESET = 4'h0;
    localparam logic [2:0] DRIVE_HALF_MAX = 3'h1;
    localparam logic [2:0] DRIVE_TQ_MAX = 3'h3;
    typedef enum logic [2:0] {
        BMCL_IDLE = 3'b001,
        BMCL_LOAD = 3'b010,
        BMCL_DONE = 3'b100
    } bmcl_state_type;
endpackage : bmcl_pkg

// [verilog/bmcl_shift_mem.sv]
/*
 * Stream store of the loader: a shift register that takes one bit per strobe,
 * first bit ending at index 0. Read data are the register itself.
 * Assumes the strobe comes from the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module bmcl_shift_mem
    import bmcl_pkg::*;
#(
    parameter int DEPTH = 256
) (
    input wire logic clk, // Primary clock.
    input wire logic reset, // Asynchronous reset, active high.
    input wire logic clear, // Empties the store.
    input wire logic shift, // Takes one bit.
    input wire logic bit_in, // Serial bit.
    output logic [DEPTH-1:0] data // Stored stream.
);
    // New bits enter at the top so the first one walks down to index 0.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            data <= '0;
        end else if (clear) begin
            data <= '0;
        end else if (shift) begin
            data <= {bit_in, data[DEPTH-1:1]};
        end
    end
endmodule : bmcl_shift_mem
`default_nettype wire

// [dv/bmcl_mem_model.sv]
/*
 * Serial configuration memory seen by the loader: shifts a stream out on the mode clock.
 * Assumes power_good rises just after a rising edge of the mode clock.
 */
`timescale 1ns/1ps
`default_nettype none
module bmcl_mem_model #(
    parameter int NBITS = 256
) (
    input wire logic power_good, // Starts the stream at position 0.
    input wire logic config_serial_clock, // Mode clock from the loader.
    input wire logic [255:0] stream, // Contents, position 0 in bit 0.
    output logic config_serial_in // Serial data to the loader.
);
    int idx;

    // Nothing is sent before the first power good, only a changing pattern.
    initial begin
        config_serial_in = 1'b0;
        idx = NBITS;
    end

    // Position 0 goes out at once so the first falling edge can take it.
    always @(posedge power_good) begin
        idx = 1;
        config_serial_in = stream[0];
    end

    // New data right after each rising edge, stable by the falling edge.
    // Reserved places carry what the bench put there, zero unless it means to break them.
    always @(posedge config_serial_clock) begin
        if (idx < NBITS) begin
            config_serial_in = stream[idx];
            idx++;
        end else begin
            config_serial_in = ~config_serial_in; // Past the end, a toggling pattern.
        end
    end
endmodule : bmcl_mem_model
`default_nettype wire

// [dv/tb.sv]
/*
 * Self-checking bench for the boot mode loader, with a model built from the field layout.
 * Assumes the loader runs with a shortened stream length so that five loads fit in the run.
 */
`timescale 1ns/1ps
`default_nettype none
module tb
    import bmcl_pkg::*;
;
    localparam int NB = 68;
    logic clk = 1'b0, reset = 1'b1, power_good = 1'b0, cold_reset_in = 1'b0;
    logic warm_reset_in = 1'b0, reduced_power_control = 1'b0, config_serial_in;
    logic config_serial_clock, load_done, cache_write_recovery, package_size_select;
    logic [3:0] cache_write_deassert_delay, cache_read_cycle_time_second;
    logic [3:0] cache_read_cycle_time_first, initial_pulldown_rate, initial_pullup_rate;
    logic [1:0] cache_write_assert_delay_second, cache_write_assert_delay_first;
    logic [2:0] cache_disable_time, low_power_clock_divisor;
    logic [4:0] pipe_divide_ratio;
    logic drive_point_half, drive_point_three_quarter, drive_point_full, slew_loop_run;
    logic slew_loop_enable_in_cold_reset, slew_loop_enable_always, clock_loop_disable;
    logic reset_float_select, output_float, reserved_error;
    logic [255:0] stream = '0;
    int err_count = 0;
    int cmp_count = 0;
    int n;

    // Primary clock, 100 ns period.
    always #50 clk = ~clk;

    bmcl_loader #(.BITS(NB)) i_dut (.clk(clk), .reset(reset), .power_good(power_good),
        .cold_reset_in(cold_reset_in), .warm_reset_in(warm_reset_in),
        .reduced_power_control(reduced_power_control), .config_serial_in(config_serial_in),
        .config_serial_clock(config_serial_clock), .load_done(load_done),
        .cache_write_deassert_delay(cache_write_deassert_delay),
        .cache_write_assert_delay_second(cache_write_assert_delay_second),
        .cache_write_assert_delay_first(cache_write_assert_delay_first),
        .cache_write_recovery(cache_write_recovery), .cache_disable_time(cache_disable_time),
        .cache_read_cycle_time_second(cache_read_cycle_time_second),
        .cache_read_cycle_time_first(cache_read_cycle_time_first),
        .package_size_select(package_size_select),
        .low_power_clock_divisor(low_power_clock_divisor), .pipe_divide_ratio(pipe_divide_ratio),
        .drive_point_half(drive_point_half), .drive_point_three_quarter(drive_point_three_quarter),
        .drive_point_full(drive_point_full), .initial_pulldown_rate(initial_pulldown_rate),
        .initial_pullup_rate(initial_pullup_rate),
        .slew_loop_enable_in_cold_reset(slew_loop_enable_in_cold_reset),
        .slew_loop_enable_always(slew_loop_enable_always), .slew_loop_run(slew_loop_run),
        .clock_loop_disable(clock_loop_disable), .reset_float_select(reset_float_select),
        .output_float(output_float), .reserved_error(reserved_error));

    bmcl_mem_model #(.NBITS(NB)) i_mem (.power_good(power_good),
        .config_serial_clock(config_serial_clock), .stream(stream),
        .config_serial_in(config_serial_in));

    // Verdict in one place; every timeout also ends here.
    task report_and_stop;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    task chk_val(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task chk_cnt(input int got, input int lo, input int hi);
        cmp_count++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask : chk_cnt

    // Inputs move a fixed 10 ns after the rising edge.
    task tick;
        @(posedge clk);
        #10;
    endtask : tick

    task wait_mc(input logic lvl, output int k);
        k = 0;
        while (config_serial_clock !== lvl) begin
            tick();
            k++;
            if (k > 400) begin
                chk_val(8'h00, 8'h01);
                report_and_stop();
            end
        end
    endtask : wait_mc

    // Field value with its top bit at the highest stream position.
    function automatic logic [7:0] fld(input int lsb, input int w);
        int s = 0;
        for (int i = 0; i < w; i++) s += int'(stream[lsb+i]) << i;
        return 8'(s);
    endfunction : fld

    // Rate fields put their top bit at the lowest stream position.
    function automatic logic [7:0] rev4(input int pos);
        int s = 0;
        for (int i = 0; i < 4; i++) s += int'(stream[pos+i]) << (3 - i);
        return 8'(s);
    endfunction : rev4

    task put(input int lsb, input int w, input int v);
        for (int i = 0; i < w; i++) stream[lsb+i] = v[i];
    endtask : put

    // Legal random fields with the divisor code given; a bad stream sets two reserved places.
    task build(input int dv, input bit bad);
        stream = '0;
        for (int i = 0; i < WR_DEASSERT_LSB; i++) stream[i] = 1'($urandom_range(1, 0));
        put(WR_DEASSERT_LSB, 4, $urandom_range(15, 3));
        put(WR_ASSERT2_LSB, 2, $urandom_range(3, 1));
        put(WR_ASSERT1_LSB, 2, $urandom_range(3, 1));
        put(WR_RECOVERY_POS, 1, $urandom_range(1, 0));
        put(DISABLE_LSB, 3, $urandom_range(7, 2));
        put(READ2_LSB, 4, $urandom_range(15, 3));
        put(READ1_LSB, 4, $urandom_range(15, 4));
        put(PKG_SIZE_POS, 1, $urandom_range(1, 0));
        put(DIVISOR_LSB, 3, dv);
        put(DRIVE_LSB, 11, $urandom_range(2047, 0));
        put(SLEW_COLD_POS, 4, $urandom_range(15, 0));
        if (bad) begin
            stream[RESV_LO_LSB+2] = 1'b1;
            stream[NB-1] = 1'b1;
        end
    endtask : build

    task check_fields(input bit bad);
        logic [7:0] d;
        d = fld(DRIVE_LSB, 3);
        chk_val(cache_write_deassert_delay, fld(WR_DEASSERT_LSB, 4));
        chk_val(cache_write_assert_delay_second, fld(WR_ASSERT2_LSB, 2));
        chk_val(cache_write_assert_delay_first, fld(WR_ASSERT1_LSB, 2));
        chk_val(cache_write_recovery, fld(WR_RECOVERY_POS, 1));
        chk_val(cache_disable_time, fld(DISABLE_LSB, 3));
        chk_val(cache_read_cycle_time_second, fld(READ2_LSB, 4));
        chk_val(cache_read_cycle_time_first, fld(READ1_LSB, 4));
        chk_val({low_power_clock_divisor, package_size_select}, fld(DIVISOR_LSB - 1, 4));
        chk_val({drive_point_full, drive_point_three_quarter, drive_point_half},
            d < 2 ? 8'h01 : (d < 4 ? 8'h02 : 8'h04));
        chk_val(initial_pulldown_rate, rev4(PULLDOWN_MSB_POS));
        chk_val(initial_pullup_rate, rev4(PULLUP_MSB_POS));
        chk_val({reset_float_select, clock_loop_disable, slew_loop_enable_always,
            slew_loop_enable_in_cold_reset}, fld(SLEW_COLD_POS, 4));
        chk_val({reserved_error, load_done}, {6'h0, bad, 1'b1});
    endtask : check_fields

    // All reset and power-mode pin mixes against the held bits.
    task check_run(input int dv);
        for (int c = 0; c < 8; c++) begin
            {reduced_power_control, warm_reset_in, cold_reset_in} = 3'(c);
            // Reset pins pass the three-stage filter and a level stage before the outputs move.
            repeat (6) tick();
            chk_val(slew_loop_run, stream[SLEW_ALWAYS_POS] | (stream[SLEW_COLD_POS] & c[0]));
            chk_val(output_float, c[0] | (stream[FLOAT_SEL_POS] & c[1]));
            chk_val(pipe_divide_ratio, !c[2] ? 8'h01 : (dv > 3 ? 8'h10 : 8'(2 << dv)));
        end
        {reduced_power_control, warm_reset_in, cold_reset_in} = 3'h0;
    endtask : check_run

    task do_load(input int dv, input bit bad);
        logic [7:0] prev;
        int k;
        prev = fld(READ1_LSB, 4);
        build(dv, bad);
        wait_mc(1'b0, k);
        wait_mc(1'b1, k);
        power_good = 1'b1;
        k = 0;
        // A held load_done from the previous load must drop before the new one counts.
        while (k < 8 || load_done !== 1'b1) begin
            tick();
            k++;
            if (k == 8) chk_val(load_done, 8'h00);
            if (k == 1000) chk_val(cache_read_cycle_time_first, prev);
            if (k > NB * MODE_CLOCK_DIV + 400) begin
                chk_val(load_done, 8'h01);
                report_and_stop();
            end
        end
        chk_cnt(k, (NB - 1) * MODE_CLOCK_DIV + 120, (NB - 1) * MODE_CLOCK_DIV + 136);
        tick();
        check_fields(bad);
        check_run(dv);
        power_good = 1'b0;
        repeat (10) tick();
    endtask : do_load

    // Reset values, five loads over the divisor codes, free-running clock after a load.
    initial begin
        void'($urandom(72384));
        repeat (4) @(posedge clk);
        #10;
        chk_val({config_serial_clock, load_done, output_float, drive_point_half}, 8'h03);
        chk_val({initial_pulldown_rate, initial_pullup_rate}, {PULLDOWN_RESET, PULLUP_RESET});
        chk_val(pipe_divide_ratio, 8'h01);
        reset = 1'b0;
        do_load(0, 1'b0);
        wait_mc(1'b0, n);
        wait_mc(1'b1, n);
        wait_mc(1'b0, n);
        chk_cnt(n, HALF_DIV, HALF_DIV);
        wait_mc(1'b1, n);
        chk_cnt(n, HALF_DIV, HALF_DIV);
        check_fields(1'b0);
        for (int dv = 1; dv < 4; dv++) do_load(dv, 1'b0);
        do_load(5, 1'b1);
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
